// File: core/ecgf_chop.sv
// chop clock generator for the central-terminal amplifiers
`timescale 1ns/1ps
`include "ecgf_defs.svh"
module ecgf_chop
  import ecgf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] rate,
  output logic            chop
);
  logic [15:0] cnt_r;
  logic [15:0] half_w;
  logic        chop_r;

  // fast rates chop at the data rate, slow rates stay at the fixed frequency
  assign half_w = (rate < `ECGF_RATE_SLOW_MIN) ?
                  16'((`ECGF_HALF_TOP_CYC) << rate) : 16'(`ECGF_HALF_FIX_CYC);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r  <= 16'h0000;
      chop_r <= 1'b0;
    end else if (cnt_r + 16'h0001 >= half_w) begin
      cnt_r  <= 16'h0000;
      chop_r <= ~chop_r;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
    end
  end
  assign chop = chop_r;
endmodule : ecgf_chop

// File: core/ecgf_ctrl.sv
// ecg front-end routing, central-terminal and electrode check control with avalon-mm registers
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ecgf_defs.svh"

module ecgf_ctrl
  import ecgf_pkg::*;
#(
  parameter int NCH = `ECGF_NCH,
  parameter bit HAS_AUG = 1'b1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [6:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             conv_done,
  input  wire logic [NCH-1:0]   comp_pos,
  input  wire logic [NCH-1:0]   comp_neg,
  output logic      [NCH-1:0]   drive_feedback_pos_en,
  output logic      [NCH-1:0]   drive_feedback_neg_en,
  output logic      [NCH-1:0]   channel_power_down,
  output logic      [7:0]       terminal_amp_a_route,
  output logic      [7:0]       terminal_amp_b_route,
  output logic      [7:0]       terminal_amp_c_route,
  output logic                  terminal_amp_a_power,
  output logic                  terminal_amp_b_power,
  output logic                  terminal_amp_c_power,
  output logic                  terminal_chop,
  output logic      [2:0]       augmented_route_en,
  output logic                  terminal_to_drive_buffer_en,
  output logic      [NCH-1:0]   electrode_check_pos_enable,
  output logic      [NCH-1:0]   electrode_check_neg_enable,
  output logic      [NCH-1:0]   pull_up_pos,
  output logic      [NCH-1:0]   pull_down_pos,
  output logic      [NCH-1:0]   pull_up_neg,
  output logic      [NCH-1:0]   pull_down_neg,
  output logic      [NCH-1:0]   source_pos,
  output logic      [NCH-1:0]   sink_pos,
  output logic      [NCH-1:0]   source_neg,
  output logic      [NCH-1:0]   sink_neg,
  output logic      [1:0]       excitation_current_level,
  output logic      [2:0]       comparator_threshold,
  output logic                  comparator_power_down,
  output logic      [NCH-1:0]   electrode_off_status_pos,
  output logic      [NCH-1:0]   electrode_off_status_neg,
  output logic      [2*NCH-1:0] frame_status
);
  import ecgf_pkg::*;

  // electrode index 0..7 = ch1P, ch1N, ch2P, ... ch4N
  function automatic logic [7:0] sel_onehot(input logic [2:0] sel);
    sel_onehot = 8'h01 << sel;
  endfunction : sel_onehot

  function automatic ecgf_byte_t merge(input ecgf_byte_t old, input logic [31:0] wd, input logic be0);
    merge = be0 ? wd[7:0] : old;
  endfunction : merge

  ecgf_byte_t  ch_set_r [NCH];
  ecgf_byte_t  term1_r;
  ecgf_byte_t  term2_r;
  ecgf_byte_t  cfg_four_r;
  ecgf_byte_t  echk_cfg_r;
  ecgf_byte_t  echk_pos_r;
  ecgf_byte_t  echk_neg_r;
  ecgf_byte_t  pol_swap_r;
  logic [2:0]  rate_r;
  logic [NCH-1:0] stat_pos_r;
  logic [NCH-1:0] stat_neg_r;
  logic [31:0] rdata_r;
  ecgf_bus_e   bus_r;
  logic [NCH-1:0] cmp_pos_s;
  logic [NCH-1:0] cmp_neg_s;

  // word index from byte address
  wire  [4:0]  idx_w    = avs_address[6:2];
  wire         req_w    = (avs_read | avs_write) && (bus_r == ECGF_BUS_IDLE);
  // a write lands on the edge that sees waitrequest low, not on the wait cycle
  wire         wr_w     = avs_write && (bus_r == ECGF_BUS_ACK);
  wire         is_ch_w  = (idx_w < 5'(NCH));
  wire  [2:0]  chi_w    = idx_w[2:0];
  wire         cmp_on_w = ~cfg_four_r[`ECGF_C4_CMP_PD];

  // single wait cycle then acknowledge
  assign avs_waitrequest = (avs_read | avs_write) && (bus_r == ECGF_BUS_IDLE);
  assign avs_readdata    = rdata_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_r <= ECGF_BUS_IDLE;
    end else if (req_w) begin
      bus_r <= ECGF_BUS_ACK;
    end else begin
      bus_r <= ECGF_BUS_IDLE;
    end
  end

  // read mux, unmapped words read zero
  logic [31:0] rd_w;
  always_comb begin
    rd_w = 32'h0000_0000;
    if (is_ch_w) begin
      rd_w = {24'h000000, ch_set_r[chi_w]};
    end else if (idx_w == 5'(`ECGF_IDX_TERM1)) begin
      rd_w = {24'h000000, term1_r};
    end else if (idx_w == 5'(`ECGF_IDX_TERM2)) begin
      rd_w = {24'h000000, term2_r};
    end else if (idx_w == 5'(`ECGF_IDX_CFG_FOUR)) begin
      rd_w = {24'h000000, cfg_four_r};
    end else if (idx_w == 5'(`ECGF_IDX_ECHK_CFG)) begin
      rd_w = {24'h000000, echk_cfg_r};
    end else if (idx_w == 5'(`ECGF_IDX_ECHK_POS)) begin
      rd_w = {24'h000000, echk_pos_r};
    end else if (idx_w == 5'(`ECGF_IDX_ECHK_NEG)) begin
      rd_w = {24'h000000, echk_neg_r};
    end else if (idx_w == 5'(`ECGF_IDX_POL_SWAP)) begin
      rd_w = {24'h000000, pol_swap_r};
    end else if (idx_w == 5'(`ECGF_IDX_STAT_POS)) begin
      rd_w = 32'(stat_pos_r);
    end else if (idx_w == `ECGF_IDX_STAT_NEG) begin
      rd_w = 32'(stat_neg_r);
    end else if (idx_w == `ECGF_IDX_RATE) begin
      rd_w = {29'h0, rate_r};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (req_w && avs_read) begin
      rdata_r <= rd_w;
    end
  end

  // channel set registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ch_set_r[i] <= 8'h00;
      end
    end else if (wr_w && is_ch_w) begin
      ch_set_r[chi_w] <= merge(ch_set_r[chi_w], avs_writedata, avs_byteenable[0]);
    end
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      term1_r    <= `ECGF_TERM1_RST;
      term2_r    <= `ECGF_TERM2_RST;
      cfg_four_r <= 8'h00;
      echk_cfg_r <= 8'h00;
      echk_pos_r <= 8'h00;
      echk_neg_r <= 8'h00;
      pol_swap_r <= 8'h00;
      rate_r     <= `ECGF_RATE_RST;
    end else if (wr_w && avs_byteenable[0]) begin
      if (idx_w == 5'(`ECGF_IDX_TERM1)) begin
        term1_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_TERM2)) begin
        term2_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_CFG_FOUR)) begin
        cfg_four_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_ECHK_CFG)) begin
        echk_cfg_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_ECHK_POS)) begin
        echk_pos_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_ECHK_NEG)) begin
        echk_neg_r <= avs_writedata[7:0];
      end else if (idx_w == 5'(`ECGF_IDX_POL_SWAP)) begin
        pol_swap_r <= avs_writedata[7:0];
      end else if (idx_w == `ECGF_IDX_RATE) begin
        rate_r <= avs_writedata[2:0];
      end
    end
  end

  // input mux: feedback input onto P or N side per channel
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      drive_feedback_pos_en[i] = (ch_set_r[i][2:0] == `ECGF_MUX_FB_POS);
      drive_feedback_neg_en[i] = (ch_set_r[i][2:0] == `ECGF_MUX_FB_NEG);
      channel_power_down[i]    = ch_set_r[i][`ECGF_CH_PD_BIT];
    end
  end

  // central-terminal amplifiers
  assign terminal_amp_a_route = sel_onehot(term1_r[2:0]);
  assign terminal_amp_b_route = sel_onehot(term2_r[5:3]);
  assign terminal_amp_c_route = sel_onehot(term2_r[2:0]);
  assign terminal_amp_a_power = term1_r[`ECGF_T1_PWR_A];
  assign terminal_amp_b_power = term1_r[`ECGF_T1_PWR_B];
  assign terminal_amp_c_power = term2_r[`ECGF_T2_PWR_C];
  // augmented leads need channels 5 to 7, so only on the eight-channel build
  assign augmented_route_en   = (HAS_AUG && NCH == 8) ? term1_r[5:3] : 3'b000;
  assign terminal_to_drive_buffer_en = cfg_four_r[`ECGF_C4_BUF_EN];

  ecgf_chop u_chop (
    .mclk (mclk),
    .rst  (rst),
    .rate (rate_r),
    .chop (terminal_chop)
  );

  // electrode check excitation
  wire exc_on_w  = ~echk_cfg_r[`ECGF_EC_EXC_OFF];
  wire use_res_w = echk_cfg_r[`ECGF_EC_TYPE];
  wire [NCH-1:0] en_p_w = echk_pos_r[NCH-1:0] & {NCH{exc_on_w}};
  wire [NCH-1:0] en_n_w = echk_neg_r[NCH-1:0] & {NCH{exc_on_w}};
  wire [NCH-1:0] sw_w   = pol_swap_r[NCH-1:0];

  assign electrode_check_pos_enable = echk_pos_r[NCH-1:0];
  assign electrode_check_neg_enable = echk_neg_r[NCH-1:0];
  // default: P side pulled up, N side pulled down; swap exchanges them
  assign pull_up_pos   = en_p_w & ~sw_w & {NCH{use_res_w}};
  assign pull_down_pos = en_p_w &  sw_w & {NCH{use_res_w}};
  assign pull_up_neg   = en_n_w &  sw_w & {NCH{use_res_w}};
  assign pull_down_neg = en_n_w & ~sw_w & {NCH{use_res_w}};
  assign source_pos    = en_p_w & ~sw_w & {NCH{~use_res_w}};
  assign sink_pos      = en_p_w &  sw_w & {NCH{~use_res_w}};
  assign source_neg    = en_n_w &  sw_w & {NCH{~use_res_w}};
  assign sink_neg      = en_n_w & ~sw_w & {NCH{~use_res_w}};
  assign excitation_current_level = echk_cfg_r[3:2];
  assign comparator_threshold     = echk_cfg_r[7:5];
  assign comparator_power_down    = ~cmp_on_w;

  // comparators are asynchronous to mclk
  ecgf_sync #(.W(NCH)) u_sync_p (
    .mclk (mclk),
    .rst  (rst),
    .din  (comp_pos),
    .dout (cmp_pos_s)
  );
  ecgf_sync #(.W(NCH)) u_sync_n (
    .mclk (mclk),
    .rst  (rst),
    .din  (comp_neg),
    .dout (cmp_neg_s)
  );

  // capture once per conversion so each frame is self-consistent
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_pos_r <= '0;
      stat_neg_r <= '0;
    end else if (conv_done) begin
      stat_pos_r <= cmp_pos_s & echk_pos_r[NCH-1:0] & {NCH{cmp_on_w}};
      stat_neg_r <= cmp_neg_s & echk_neg_r[NCH-1:0] & {NCH{cmp_on_w}};
    end
  end

  assign electrode_off_status_pos = stat_pos_r;
  assign electrode_off_status_neg = stat_neg_r;
  assign frame_status = {stat_pos_r, stat_neg_r};
endmodule : ecgf_ctrl

// File: core/ecgf_defs.svh
// offsets, field positions, reset values and timing counts for the ecg front-end control block
`ifndef ECGF_DEFS_SVH
`define ECGF_DEFS_SVH

`define ECGF_NCH            8
// register word offsets (byte address = 4 * index)
`define ECGF_IDX_CH_SET0    5'h00
`define ECGF_IDX_TERM1      5'h08
`define ECGF_IDX_TERM2      5'h09
`define ECGF_IDX_CFG_FOUR   5'h0A
`define ECGF_IDX_ECHK_CFG   5'h0B
`define ECGF_IDX_ECHK_POS   5'h0C
`define ECGF_IDX_ECHK_NEG   5'h0D
`define ECGF_IDX_POL_SWAP   5'h0E
`define ECGF_IDX_STAT_POS   5'h0F
`define ECGF_IDX_STAT_NEG   5'h10
`define ECGF_IDX_RATE       5'h11
`define ECGF_IDX_LAST       5'h11
// channel set register: input select [2:0], power down bit 7
`define ECGF_MUX_LSB        0
`define ECGF_CH_PD_BIT      7
`define ECGF_MUX_FB_POS     3'h6
`define ECGF_MUX_FB_NEG     3'h7
// terminal register 1: a power bit 7, b power bit 6, augmented enable bit 5..3, a select [2:0]
`define ECGF_T1_PWR_A       7
`define ECGF_T1_PWR_B       6
`define ECGF_T1_AUG_LSB     3
`define ECGF_T1_SEL_A_LSB   0
// terminal register 2: c power bit 7, b select [5:3], c select [2:0]
`define ECGF_T2_PWR_C       7
`define ECGF_T2_SEL_B_LSB   3
`define ECGF_T2_SEL_C_LSB   0
`define ECGF_TERM1_RST      8'h00
`define ECGF_TERM2_RST      8'h04
// config four: buffer enable bit 2, comparator power down bit 1
`define ECGF_C4_BUF_EN      2
`define ECGF_C4_CMP_PD      1
// electrode check config: threshold [7:5], excitation type bit 4, current [3:2], excitation off bit 0
`define ECGF_EC_TH_LSB      5
`define ECGF_EC_TYPE        4
`define ECGF_EC_CUR_LSB     2
`define ECGF_EC_EXC_OFF     0
// rate code 0 = 32 kSPS ... 6 = 500 SPS
`define ECGF_RATE_RST       3'h6
`define ECGF_RATE_SLOW_MIN  3'h3
`define ECGF_CLK_HZ         250000000
`define ECGF_CHOP_FIXED_HZ  4000
`define ECGF_TOP_RATE_HZ    32000
// half-period of the chop clock at the top rate and at the fixed 4 kHz
`define ECGF_HALF_TOP_CYC   (`ECGF_CLK_HZ / (2 * `ECGF_TOP_RATE_HZ))
`define ECGF_HALF_FIX_CYC   (`ECGF_CLK_HZ / (2 * `ECGF_CHOP_FIXED_HZ))

`endif

// File: core/ecgf_pkg.sv
// types shared by the ecg front-end control block
package ecgf_pkg;
  typedef logic [7:0] ecgf_byte_t;
  typedef enum logic [1:0] {
    ECGF_BUS_IDLE = 2'b00,
    ECGF_BUS_ACK  = 2'b01
  } ecgf_bus_e;
endpackage : ecgf_pkg

// File: core/ecgf_sync.sv
// three-stage synchroniser for comparator outputs, a change counts when stages two and three agree
`timescale 1ns/1ps
module ecgf_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
  end
  assign dout = q_r;
endmodule : ecgf_sync

// File: verif/ecgf_afe_model.sv
// far-side model: conversion strobe and lead-off comparator outputs
`timescale 1ns/1ps
module ecgf_afe_model #(
  parameter int CONV_GAP = 40
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] set_pos,
  input  wire logic [7:0] set_neg,
  output logic            conv_done,
  output logic      [7:0] comp_pos,
  output logic      [7:0] comp_neg
);
  int cnt_r;
  // comparator levels follow the bench settings; the design still synchronises them
  always_ff @(posedge mclk) begin
    comp_pos <= set_pos;
    comp_neg <= set_neg;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 0;
      conv_done <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == CONV_GAP - 1) ? 0 : cnt_r + 1;
      conv_done <= (cnt_r == CONV_GAP - 1);
    end
  end
endmodule : ecgf_afe_model

// File: verif/ecgf_ctrl_asserts.sv
// concurrent checks on the ports of the ecg front-end control block
`timescale 1ns/1ps
module ecgf_ctrl_asserts #(
  parameter int NCH = 8
) (
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  input wire logic             conv_done,
  input wire logic [NCH-1:0]   drive_feedback_pos_en,
  input wire logic [NCH-1:0]   drive_feedback_neg_en,
  input wire logic [7:0]       terminal_amp_a_route,
  input wire logic             terminal_chop,
  input wire logic [NCH-1:0]   pull_up_pos,
  input wire logic [NCH-1:0]   pull_up_neg,
  input wire logic [NCH-1:0]   electrode_check_pos_enable,
  input wire logic [NCH-1:0]   electrode_check_neg_enable,
  input wire logic             comparator_power_down,
  input wire logic [NCH-1:0]   electrode_off_status_pos,
  input wire logic [NCH-1:0]   electrode_off_status_neg,
  input wire logic [2*NCH-1:0] frame_status
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  fb_excl_a: assert property ((drive_feedback_pos_en & drive_feedback_neg_en) == '0)
    else $error("feedback input on both sides");
  route_hot_a: assert property ($onehot(terminal_amp_a_route))
    else $error("terminal route not one-hot");
  wait_once_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");
  stat_hold_a: assert property (!conv_done |=> $stable(electrode_off_status_pos) && $stable(electrode_off_status_neg))
    else $error("status moved without conversion");
  cmp_off_a: assert property (conv_done && comparator_power_down |=>
    electrode_off_status_pos == '0 && electrode_off_status_neg == '0)
    else $error("status set with comparators off");
  frame_match_a: assert property (frame_status == {electrode_off_status_pos, electrode_off_status_neg})
    else $error("frame status differs");
  side_excl_a: assert property ((pull_up_pos & pull_up_neg) == '0)
    else $error("both sides pulled up");
  chop_rate_a: assert property (!$stable(terminal_chop) |=> $stable(terminal_chop) [*8])
    else $error("chop toggles too fast");
  stat_sense_a: assert property (conv_done |=>
    (electrode_off_status_pos & ~$past(electrode_check_pos_enable)) == '0 &&
    (electrode_off_status_neg & ~$past(electrode_check_neg_enable)) == '0)
    else $error("status set on unsensed input");
endmodule : ecgf_ctrl_asserts

bind ecgf_ctrl ecgf_ctrl_asserts #(.NCH(NCH)) u_chk (
  .mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .conv_done(conv_done), .drive_feedback_pos_en(drive_feedback_pos_en),
  .drive_feedback_neg_en(drive_feedback_neg_en), .terminal_amp_a_route(terminal_amp_a_route),
  .terminal_chop(terminal_chop), .pull_up_pos(pull_up_pos), .pull_up_neg(pull_up_neg),
  .electrode_check_pos_enable(electrode_check_pos_enable),
  .electrode_check_neg_enable(electrode_check_neg_enable),
  .comparator_power_down(comparator_power_down), .electrode_off_status_pos(electrode_off_status_pos),
  .electrode_off_status_neg(electrode_off_status_neg), .frame_status(frame_status)
);

// File: verif/ecgf_ctrl_tb_top.sv
// self-checking bench for the ecg front-end control block
`timescale 1ns/1ps
`include "ecgf_defs.svh"
module ecgf_ctrl_tb_top;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest, conv_done, chop, buf_en, cmp_pd, pa, pb, pc;
  logic [6:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [7:0]  cmp_p, cmp_n, set_p, set_n, fb_p, fb_n, ch_pd, rt_a, rt_b, rt_c, sen_p, sen_n;
  logic [7:0]  pu_p, pd_p, pu_n, pd_n, so_p, si_p, so_n, si_n, st_p, st_n;
  logic [15:0] frame;
  logic [2:0]  aug, th;
  logic [1:0]  cur;
  int          err_total, cmp_count, n;

  ecgf_ctrl u_dut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_done(conv_done), .comp_pos(cmp_p), .comp_neg(cmp_n),
    .drive_feedback_pos_en(fb_p), .drive_feedback_neg_en(fb_n), .channel_power_down(ch_pd),
    .terminal_amp_a_route(rt_a), .terminal_amp_b_route(rt_b), .terminal_amp_c_route(rt_c),
    .terminal_amp_a_power(pa), .terminal_amp_b_power(pb), .terminal_amp_c_power(pc), .terminal_chop(chop),
    .augmented_route_en(aug), .terminal_to_drive_buffer_en(buf_en), .electrode_check_pos_enable(sen_p),
    .electrode_check_neg_enable(sen_n), .pull_up_pos(pu_p), .pull_down_pos(pd_p), .pull_up_neg(pu_n),
    .pull_down_neg(pd_n), .source_pos(so_p), .sink_pos(si_p), .source_neg(so_n), .sink_neg(si_n),
    .excitation_current_level(cur), .comparator_threshold(th), .comparator_power_down(cmp_pd),
    .electrode_off_status_pos(st_p), .electrode_off_status_neg(st_n), .frame_status(frame)
  );
  ecgf_afe_model u_afe (
    .mclk(mclk), .rst(rst), .set_pos(set_p), .set_neg(set_n), .conv_done(conv_done),
    .comp_pos(cmp_p), .comp_neg(cmp_n)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is sampled low; a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] d);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rc(input logic [4:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, exp});
  endtask : rc

  task automatic half(output int cyc);
    logic c;
    cyc = 0;
    @(negedge mclk);
    c = chop;
    while (chop === c) @(negedge mclk);
    c = chop;
    while (chop === c) begin
      @(negedge mclk);
      cyc++;
    end
  endtask : half

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    results();
  end

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {3'b100, 39'h0, 4'hF};
    {set_p, set_n} = 16'h0;
    repeat (16) @(posedge mclk);
    chk({rt_a, rt_b, rt_c, pa, pb, pc, chop}, {8'h01, 8'h01, 8'h10, 4'h0});
    rst <= 1'b0;
    rc(`ECGF_IDX_TERM1, 8'h00);
    rc(`ECGF_IDX_TERM2, 8'h04);
    rc(`ECGF_IDX_RATE, 8'h06);
    bus(1'b1, 5'h12, 8'hFF);
    rc(5'h12, 8'h00);
    bus(1'b1, `ECGF_IDX_STAT_POS, 8'hFF);
    rc(`ECGF_IDX_STAT_POS, 8'h00);
    avs_byteenable <= 4'hE;
    bus(1'b1, `ECGF_IDX_ECHK_POS, 8'hFF);
    avs_byteenable <= 4'hF;
    rc(`ECGF_IDX_ECHK_POS, 8'h00);
    bus(1'b1, `ECGF_IDX_CH_SET0, 8'h06);
    bus(1'b1, 5'h7, 8'h87);
    @(negedge mclk);
    chk({fb_p, fb_n, ch_pd}, 24'h018080);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `ECGF_IDX_TERM1, {k[1:0], k[2:0], k[2:0]});
      bus(1'b1, `ECGF_IDX_TERM2, {k[2], 1'b0, k[2:0], ~k[2:0]});
      @(negedge mclk);
      chk({rt_a, rt_b, rt_c}, {8'h01 << k, 8'h01 << k, 8'h80 >> k});
      chk({pa, pb, pc, aug}, {k[1], k[0], k[2], k[2:0]});
    end
    bus(1'b1, `ECGF_IDX_CFG_FOUR, 8'h04);
    @(negedge mclk);
    chk({buf_en, cmp_pd}, 2'b10);
    bus(1'b1, `ECGF_IDX_ECHK_POS, 8'h0F);
    bus(1'b1, `ECGF_IDX_ECHK_NEG, 8'h3C);
    bus(1'b1, `ECGF_IDX_POL_SWAP, 8'h55);
    // resistor, then current source, then excitation off with sensing kept
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `ECGF_IDX_ECHK_CFG, {3'h5, m == 0, 2'h2, 1'b0, m == 2});
      @(negedge mclk);
      chk({pu_p, pd_p, pu_n, pd_n}, (m == 0) ? 32'h0A051428 : 32'h0);
      chk({so_p, si_p, so_n, si_n}, (m == 1) ? 32'h0A051428 : 32'h0);
      chk({th, cur, sen_p, sen_n}, {3'h5, 2'h2, 16'h0F3C});
    end
    set_p <= 8'hFF;
    set_n <= 8'h81;
    bus(1'b1, `ECGF_IDX_CFG_FOUR, 8'h00);
    repeat (3) @(posedge conv_done);
    @(negedge mclk);
    chk(frame, 16'h0F00);
    chk({st_p, st_n}, 16'h0F00);
    rc(`ECGF_IDX_STAT_POS, 8'h0F);
    rc(`ECGF_IDX_STAT_NEG, 8'h00);
    set_n <= 8'h3C;
    repeat (3) @(posedge conv_done);
    rc(`ECGF_IDX_STAT_NEG, 8'h3C);
    bus(1'b1, `ECGF_IDX_CFG_FOUR, 8'h02);
    repeat (2) @(posedge conv_done);
    @(negedge mclk);
    chk({cmp_pd, frame}, 17'h10000);
    chk({st_p, st_n}, 16'h0000);
    bus(1'b1, `ECGF_IDX_RATE, 8'h00);
    half(n);
    chk(n, `ECGF_HALF_TOP_CYC);
    bus(1'b1, `ECGF_IDX_RATE, 8'h04);
    half(n);
    chk(n, `ECGF_HALF_FIX_CYC);
    results();
  end
endmodule : ecgf_ctrl_tb_top
